/* File: rtl/i2sc_pkg.sv */
package i2sc_pkg;

   // Register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_MODE   = 8'h00;  // power_save_mode_reg
   localparam logic [7:0] OFS_CTRL   = 8'h04;  // power_save_control_reg
   localparam logic [7:0] OFS_OSC_STABILIZE_SELECT_REG   = 8'h08;  // osc_stabilize_select_reg
   localparam logic [7:0] OFS_CLKCFG = 8'h0C;  // Clock source configuration
   localparam logic [7:0] OFS_SERCFG = 8'h10;  // Serial clock source selects
   localparam logic [7:0] OFS_STATUS = 8'h14;  // Standby status, read only

   // power_save_mode_reg fields
   localparam int unsigned MODE_LO_BIT = 0;    // mode_select_lo
   localparam int unsigned MODE_HI_BIT = 1;    // mode_select_hi
   localparam logic [1:0]  MODE_IDLE2  = 2'h2; // Binary 10 selects this idle mode
   localparam logic [1:0]  MODE_RST    = 2'h0;

   // power_save_control_reg fields
   localparam int unsigned STOP_BIT  = 1;      // stop_request_bit, self clearing
   localparam int unsigned MASKABLE_WAKE_MASK_BIT  = 4;      // maskable_wake_mask
   localparam int unsigned NONMASK_WAKE_MASK_0_BIT = 5;      // nonmask_wake_mask_0 (pin)
   localparam int unsigned NONMASK_WAKE_MASK_1_BIT = 6;      // nonmask_wake_mask_1 (watchdog)
   localparam logic [2:0]  MASK_RST  = 3'h0;

   // osc_stabilize_select_reg: interval is 2^(STAB_SHIFT_BASE + value) cycles
   localparam int unsigned STAB_W          = 20;
   localparam int unsigned STAB_SHIFT_BASE = 12;
   localparam logic [2:0]  OSC_STABILIZE_SELECT_REG_RST        = 3'h4;       // 2^16 main clock periods
   localparam int unsigned RESET_STAB_CYC  = 65536;      // Reset value interval

   // Clock configuration fields
   localparam int unsigned CFG_SUB_BIT  = 0;   // Subclock in use
   localparam int unsigned CFG_ITM_LSB  = 1;   // interval_timer source, 2 bits
   localparam int unsigned CFG_WTM_LSB  = 3;   // Watch timer source, 2 bits
   localparam int unsigned CFG_WDT_LSB  = 5;   // Watchdog source, 2 bits
   localparam logic [6:0]  CFG_RST      = 7'h00;
   localparam logic [5:0]  SER_RST      = 6'h00;

   // Clock source codes shared by the source fields
   localparam logic [1:0] SRC_MAIN    = 2'h0;  // Main clock, stops in idle
   localparam logic [1:0] SRC_INTOSC  = 2'h1;  // internal_osc_clock (or /8)
   localparam logic [1:0] SRC_SUB     = 2'h2;  // Subclock
   localparam logic [1:0] SRC_BRGDIV  = 2'h3;  // Main clock via divided baud_rate_generator

   // Channel counts
   localparam int unsigned EXT_IRQ_N = 9;      // external_irq_pins
   localparam int unsigned SER_N     = 6;      // clocked_serial_channels
   localparam int unsigned PRIO_W    = 3;      // Lower value is higher priority

   // Sequencer states
   typedef enum logic [1:0] {
      I2SC_NORMAL = 2'b00,
      I2SC_IDLE   = 2'b01,
      I2SC_SETUP  = 2'b10
   } i2sc_state_t;

endpackage : i2sc_pkg

/* File: rtl/i2sc_sync.sv */
`timescale 1ns/10ps
module i2sc_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             arst_n_i,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   // One two-stage synchroniser per bit
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic meta;  // First stage, read only by the second stage

         always_ff @(posedge clock_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               meta      <= 1'b0;
               sync_o[g] <= 1'b0;
            end else begin
               meta      <= async_i[g];
               sync_o[g] <= meta;
            end
         end
      end
   endgenerate

endmodule : i2sc_sync

/* File: rtl/i2sc_stab_timer.sv */
`timescale 1ns/10ps
module i2sc_stab_timer
   import i2sc_pkg::*;
(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              arst_n_i,
   // Control
   input  wire logic              start_i,    // Loads the interval and starts
   input  wire logic [STAB_W-1:0] length_i,   // Interval in clock cycles
   // Status
   output logic                   busy_o,
   output logic                   done_o      // One-cycle overflow pulse
);

   logic [STAB_W-1:0] count;  // Cycles still to run

   // Down counter; overflow pulse when the last cycle passes
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count  <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (start_i) begin
         // Zero would wrap and run 2^20 cycles, so it is treated as one cycle
         count  <= (length_i == '0) ? STAB_W'(1) : length_i;
         busy_o <= 1'b1;
         done_o <= 1'b0;
      end else if (busy_o) begin
         count  <= count - STAB_W'(1);
         busy_o <= (count != STAB_W'(1));
         done_o <= (count == STAB_W'(1));
      end else begin
         done_o <= 1'b0;
      end
   end

endmodule : i2sc_stab_timer

/* File: rtl/i2sc_ctrl.sv */
// Contract
// - Mode 10 plus stop bit enters idle
// - Oscillators run; CPU, PLL, flash clocks stop
// - Execution halts, internal RAM retained
// - Subclock or external clocked peripherals keep running
// - Wait PLL and flash setup before resuming
// - Pending unmasked request wakes at once
// - NMI, watchdog, unmasked pin or peripheral wakes
// - Any reset source wakes as normal reset
// - PLL returns to its pre-idle state
// - Lower priority request wakes, stays pending
// - Higher priority or NMI wakes and acknowledged
// - Set mask bits make those requests invalid
// - NMI wake branches to handler after setup
// - Maskable wake branches or continues per EI
// - PLL, CPU, DMA, timers stop; intc detects only; code stops the intc clock as well
// - Interval timer runs on osc/8 or subclock
// - Watch timer runs on divided BAUD_RATE_GENERATOR or subclock; code enables it whenever the subclock is in use, whatever its source
// - Watchdog runs on internal osc or subclock
// - Serial channels run on external clock only
// - Interrupt wake times OSC_STABILIZE_SELECT_REG interval, then resumes
// - Reset wake uses 2^16 main clock interval
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
module i2sc_ctrl #(
   parameter int unsigned RESET_STAB_CYCLES = i2sc_pkg::RESET_STAB_CYC
) (
   // Clock and reset
   input  wire logic                           clock_i,
   input  wire logic                           arst_n_i,
   // Register port
   input  wire logic [i2sc_pkg::ADDR_W-1:0]    addr_i,
   input  wire logic [i2sc_pkg::DATA_W-1:0]    wdata_i,
   input  wire logic                           wr_i,
   input  wire logic                           rd_i,
   output logic      [i2sc_pkg::DATA_W-1:0]    rdata_o,
   // Wake pins, asynchronous
   input  wire logic                           nmi_pin_i,
   input  wire logic [i2sc_pkg::EXT_IRQ_N-1:0] external_irq_pins_i,
   // Reset sources, asynchronous
   input  wire logic                           reset_pin_i,
   input  wire logic                           watchdog_reset_i,
   input  wire logic                           low_voltage_detector_i,
   input  wire logic                           clock_monitor_i,
   // Interrupt controller side, same clock
   input  wire logic                           watchdog_interrupt_i,
   input  wire logic [i2sc_pkg::EXT_IRQ_N-1:0] ext_irq_masked_i,
   input  wire logic                           periph_irq_unmasked_i,
   input  wire logic [i2sc_pkg::PRIO_W-1:0]    req_prio_i,
   input  wire logic                           in_service_i,
   input  wire logic [i2sc_pkg::PRIO_W-1:0]    svc_prio_i,
   input  wire logic                           int_enabled_i,
   // Clock generator side
   input  wire logic                           pll_on_i,
   // Clock gates
   output logic                                cpu_clk_en_o,
   output logic                                pll_enable_o,
   output logic                                flash_clk_en_o,
   output logic                                dma_clk_en_o,
   output logic                                gen_timer_clk_en_o,
   output logic                                intc_clk_en_o,
   output logic                                periph_clk_en_o,
   output logic                                interval_timer_clk_en_o,
   output logic                                watch_timer_clk_en_o,
   output logic                                watchdog_clk_en_o,
   output logic      [i2sc_pkg::SER_N-1:0]     serial_clk_en_o,
   // Standby status
   output logic                                idle_o,
   output logic                                cpu_halt_o,
   output logic                                ram_retain_o,
   output logic                                periph_hold_o,
   // Wake results, one-cycle pulses at the end of setup
   output logic                                wake_ack_o,
   output logic                                wake_branch_o,
   output logic                                wake_continue_o,
   output logic                                system_reset_req_o
);
   import i2sc_pkg::*;

   // Register state
   logic [1:0]        mode_sel;       // mode_select_hi, mode_select_lo
   logic [2:0]        wake_masks;     // {nmi1, nmi0, maskable} masks
   logic [2:0]        osc_stabilize_select_reg_sel;       // Stabilisation select
   logic [6:0]        clk_cfg;        // Clock sources of the running timers
   logic [SER_N-1:0]  ser_ext_clk;    // Per channel: serial_clock_input selected

   // Sequencer state
   i2sc_state_t       state;
   logic              pll_saved;      // PLL state captured at entry
   logic              wake_by_reset;  // Current setup follows a reset wake
   logic              wake_by_nmi;    // Current setup follows an NMI wake
   logic              wake_do_ack;    // Request will be acknowledged
   logic              wake_do_br;     // Handler branch chosen

   // Synchronised pins
   logic              nmi_pin_s;
   logic [EXT_IRQ_N-1:0] ext_pins_s;
   logic [3:0]        rst_src_s;

   // Combinational terms
   logic              entry_req;
   logic              nmi_wake;
   logic              mask_wake;
   logic              any_wake;
   logic              reset_wake;
   logic              prio_higher;
   logic              stab_start;
   logic              stab_busy;
   logic              stab_done;
   logic [STAB_W-1:0] stab_len;
   logic              in_idle;
   logic              gated;
   logic              sub_used;
   logic [1:0]        itm_src;
   logic [1:0]        wtm_src;
   logic [1:0]        wdt_src;
   logic [DATA_W-1:0] next_rdata;

   // Pins from outside the clock domain pass two flip-flops
   i2sc_sync #(
      .WIDTH (1 + EXT_IRQ_N + 4)
   ) u_sync (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .async_i  ({nmi_pin_i, external_irq_pins_i, reset_pin_i, watchdog_reset_i,
                  low_voltage_detector_i, clock_monitor_i}),
      .sync_o   ({nmi_pin_s, ext_pins_s, rst_src_s})
   );

   // Entry happens only on the control write from normal operation
   assign entry_req = wr_i && (addr_i == OFS_CTRL) && wdata_i[STOP_BIT]
                      && (mode_sel == MODE_IDLE2) && (state == I2SC_NORMAL);

   // Masked sources count as invalid and cannot wake
   assign nmi_wake  = (nmi_pin_s && !wake_masks[1])
                      || (watchdog_interrupt_i && !wake_masks[2]);
   assign mask_wake = !wake_masks[0]
                      && ((|(ext_pins_s & ~ext_irq_masked_i))
                          || periph_irq_unmasked_i);
   assign any_wake  = nmi_wake || mask_wake;
   assign reset_wake = |rst_src_s;

   // Lower value means higher priority
   assign prio_higher = !in_service_i || (req_prio_i < svc_prio_i);

   // Interval: reset value after reset wake, else programmed select
   assign stab_start = (state == I2SC_IDLE) && (reset_wake || any_wake);
   assign stab_len   = reset_wake ? STAB_W'(RESET_STAB_CYCLES)
                                  : STAB_W'(1) << (STAB_SHIFT_BASE + osc_stabilize_select_reg_sel);

   // Counts the setup interval for PLL and flash
   i2sc_stab_timer u_stab (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .start_i  (stab_start),
      .length_i (stab_len),
      .busy_o   (stab_busy),
      .done_o   (stab_done)
   );

   // Mode select register; a plain store
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_sel <= MODE_RST;
      end else if (wr_i && addr_i == OFS_MODE) begin
         mode_sel <= {wdata_i[MODE_HI_BIT], wdata_i[MODE_LO_BIT]};
      end
   end

   // Wake masks; stop bit is not stored, it acts only on the write
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_masks <= MASK_RST;
      end else if (wr_i && addr_i == OFS_CTRL) begin
         wake_masks <= {wdata_i[NONMASK_WAKE_MASK_1_BIT], wdata_i[NONMASK_WAKE_MASK_0_BIT], wdata_i[MASKABLE_WAKE_MASK_BIT]};
      end
   end

   // Stabilisation select and clock configuration
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         osc_stabilize_select_reg_sel    <= OSC_STABILIZE_SELECT_REG_RST;
         clk_cfg     <= CFG_RST;
         ser_ext_clk <= SER_RST;
      end else if (wr_i) begin
         if (addr_i == OFS_OSC_STABILIZE_SELECT_REG) begin
            osc_stabilize_select_reg_sel <= wdata_i[2:0];
         end
         if (addr_i == OFS_CLKCFG) begin
            clk_cfg <= wdata_i[6:0];
         end
         if (addr_i == OFS_SERCFG) begin
            ser_ext_clk <= wdata_i[SER_N-1:0];
         end
      end
   end

   // Sequencer: normal, idle, setup
   // The CPU clock still runs for one cycle after the entry write, which is why
   // software must pad the entry write with no-ops.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= I2SC_NORMAL;
      end else begin
         unique case (state)
            I2SC_NORMAL: begin
               if (entry_req) begin
                  state <= I2SC_IDLE;
               end
            end
            I2SC_IDLE: begin
               // A request pending at entry is seen in the first idle cycle
               if (stab_start) begin
                  state <= I2SC_SETUP;
               end
            end
            I2SC_SETUP: begin
               if (stab_done) begin
                  state <= I2SC_NORMAL;
               end
            end
            default: begin
               state <= I2SC_NORMAL;
            end
         endcase
      end
   end

   // Capture the PLL state at entry so it can be restored on release
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pll_saved <= 1'b0;
      end else if (entry_req) begin
         pll_saved <= pll_on_i;
      end
   end

   // Latch the cause and the acknowledge decision at wake time
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_by_reset <= 1'b0;
         wake_by_nmi   <= 1'b0;
         wake_do_ack   <= 1'b0;
         wake_do_br    <= 1'b0;
      end else if (stab_start) begin
         // Reset outranks interrupts; an NMI outranks maskable requests
         wake_by_reset <= reset_wake;
         wake_by_nmi   <= !reset_wake && nmi_wake;
         if (reset_wake) begin
            wake_do_ack <= 1'b0;
            wake_do_br  <= 1'b0;
         end else if (nmi_wake) begin
            // NMI is always above the serviced level, branch in EI and DI
            wake_do_ack <= 1'b1;
            wake_do_br  <= 1'b1;
         end else begin
            // Lower priority still wakes but stays pending, unacknowledged
            wake_do_ack <= prio_higher && int_enabled_i;
            wake_do_br  <= prio_higher && int_enabled_i;
         end
      end
   end

   // Decoded clock source selects
   assign sub_used = clk_cfg[CFG_SUB_BIT];
   assign itm_src  = clk_cfg[CFG_ITM_LSB +: 2];
   assign wtm_src  = clk_cfg[CFG_WTM_LSB +: 2];
   assign wdt_src  = clk_cfg[CFG_WDT_LSB +: 2];

   // Clocks stay gated through setup, because PLL and flash are not ready yet
   assign in_idle = (state == I2SC_IDLE);
   assign gated   = (state != I2SC_NORMAL);

   // Core clock gates: CPU, flash, DMA, timers and peripherals stop
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cpu_clk_en_o       <= 1'b1;
         flash_clk_en_o     <= 1'b1;
         dma_clk_en_o       <= 1'b1;
         gen_timer_clk_en_o <= 1'b1;
         periph_clk_en_o    <= 1'b1;
         intc_clk_en_o      <= 1'b1;
      end else begin
         cpu_clk_en_o       <= !gated;
         flash_clk_en_o     <= !gated;
         dma_clk_en_o       <= !gated;
         gen_timer_clk_en_o <= !gated;
         periph_clk_en_o    <= !gated;
         // Wake detection runs in this block on clock_i, so this may stop
         intc_clk_en_o      <= !gated;
      end
   end

   // PLL off while idle, back to its saved state during setup unless a reset woke it
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pll_enable_o <= 1'b0;
      end else if (in_idle || (state == I2SC_NORMAL && entry_req)) begin
         pll_enable_o <= 1'b0;
      end else if (state == I2SC_SETUP) begin
         // Start relocking during setup so the interval covers it
         pll_enable_o <= wake_by_reset ? 1'b0 : pll_saved;
      end else begin
         pll_enable_o <= pll_on_i;
      end
   end

   // Interval timer and watchdog keep counting on internal osc or subclock; watch timer on BRG divider or whenever the subclock is in use
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         interval_timer_clk_en_o <= 1'b1;
         watch_timer_clk_en_o    <= 1'b1;
         watchdog_clk_en_o       <= 1'b1;
      end else begin
         interval_timer_clk_en_o <= !gated || (itm_src == SRC_INTOSC)
                                    || (sub_used && itm_src == SRC_SUB);
         watch_timer_clk_en_o    <= !gated || sub_used
                                    || (wtm_src == SRC_BRGDIV);
         watchdog_clk_en_o       <= !gated || (wdt_src == SRC_INTOSC)
                                    || (sub_used && wdt_src == SRC_SUB);
      end
   end

   // Serial channels keep running only on their external serial clock
   genvar s;
   generate
      for (s = 0; s < SER_N; s++) begin : g_ser
         always_ff @(posedge clock_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               serial_clk_en_o[s] <= 1'b1;
            end else begin
               serial_clk_en_o[s] <= !gated || ser_ext_clk[s];
            end
         end
      end
   endgenerate

   // Standby flags: halt, RAM retention and peripheral state hold
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idle_o        <= 1'b0;
         cpu_halt_o    <= 1'b0;
         ram_retain_o  <= 1'b0;
         periph_hold_o <= 1'b0;
      end else begin
         idle_o        <= in_idle;
         cpu_halt_o    <= gated;
         // RAM is never written while halted; retention keeps it frozen
         ram_retain_o  <= gated;
         // Gated peripherals freeze registers and output levels
         periph_hold_o <= gated;
      end
   end

   // Release pulses at the overflow of the setup timer
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_ack_o         <= 1'b0;
         wake_branch_o      <= 1'b0;
         wake_continue_o    <= 1'b0;
         system_reset_req_o <= 1'b0;
      end else begin
         wake_ack_o      <= stab_done && !wake_by_reset && wake_do_ack;
         wake_branch_o   <= stab_done && !wake_by_reset && wake_do_br;
         wake_continue_o <= stab_done && !wake_by_reset && !wake_do_br;
         // Reset wake finishes as an ordinary reset after the interval
         system_reset_req_o <= stab_done && wake_by_reset;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = '0;
      unique case (addr_i)
         OFS_MODE:   next_rdata = {6'h00, mode_sel};
         OFS_CTRL:   next_rdata = {1'b0, wake_masks, 4'h0};
         OFS_OSC_STABILIZE_SELECT_REG:   next_rdata = {5'h00, osc_stabilize_select_reg_sel};
         OFS_CLKCFG: next_rdata = {1'b0, clk_cfg};
         OFS_SERCFG: next_rdata = {2'h0, ser_ext_clk};
         OFS_STATUS: next_rdata = {2'h0, stab_busy, pll_saved, wake_by_nmi,
                                   wake_by_reset, state};
         default:    next_rdata = '0;
      endcase
   end

   // Read data stand for one cycle after the strobe only
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= rd_i ? next_rdata : '0;
      end
   end

endmodule : i2sc_ctrl

/* File: verif/i2sc_ctrl_props.sv */
`timescale 1ns/10ps
module i2sc_ctrl_props (
   // Watched ports of the sequencer
   input wire logic clock_i, arst_n_i, wr_i, pll_on_i, idle_o, cpu_halt_o,
   input wire logic cpu_clk_en_o, pll_enable_o, flash_clk_en_o, dma_clk_en_o,
   input wire logic intc_clk_en_o, periph_clk_en_o,
   input wire logic gen_timer_clk_en_o, ram_retain_o, periph_hold_o, wake_ack_o,
   input wire logic wake_branch_o, wake_continue_o, system_reset_req_o
);
   default clocking dcb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   // Any kind of release pulse
   wire rel = wake_branch_o | wake_continue_o | system_reset_req_o;
   chk_idle_gates: assert property (idle_o |-> !(cpu_clk_en_o | flash_clk_en_o
      | pll_enable_o | dma_clk_en_o | gen_timer_clk_en_o | intc_clk_en_o | periph_clk_en_o))
      else $error("clock runs in idle");
   chk_halt_retain: assert property (
      idle_o |-> cpu_halt_o && ram_retain_o && periph_hold_o) else $error("state not held");
   chk_entry_write: assert property ($rose(idle_o) |-> $past(wr_i, 2) || $past(wr_i, 3))
      else $error("idle without entry write");
   // Smallest interval in use is 16 cycles, so 8 is a safe floor
   chk_setup_hold: assert property ($fell(idle_o) |-> cpu_halt_o [*8])
      else $error("setup too short");
   chk_release_run: assert property (rel |=> !cpu_halt_o && cpu_clk_en_o)
      else $error("no resume after release");
   chk_pulse_onehot: assert property ($onehot0({wake_branch_o, wake_continue_o,
      system_reset_req_o})) else $error("two release kinds at once");
   chk_ack_branch: assert property (wake_ack_o |-> wake_branch_o)
      else $error("ack without branch");
   // The entry edge already drops the PLL, one cycle before halt shows
   chk_pll_follow: assert property (!cpu_halt_o && $past(!cpu_halt_o) && $past(arst_n_i)
      |-> (pll_enable_o == $past(pll_on_i)) or (!pll_enable_o ##1 cpu_halt_o))
      else $error("pll state lost");
   cov_continue: cover property (wake_continue_o);
   cov_ack: cover property (wake_ack_o);
   cov_reset: cover property (system_reset_req_o);
endmodule : i2sc_ctrl_props
bind i2sc_ctrl i2sc_ctrl_props i_chk (.clock_i, .arst_n_i, .wr_i, .pll_on_i, .idle_o,
   .cpu_halt_o, .cpu_clk_en_o, .pll_enable_o, .flash_clk_en_o, .dma_clk_en_o,
   .intc_clk_en_o, .periph_clk_en_o,
   .gen_timer_clk_en_o, .ram_retain_o, .periph_hold_o, .wake_ack_o, .wake_branch_o,
   .wake_continue_o, .system_reset_req_o);

/* File: verif/i2sc_partner.sv */
`timescale 1ns/10ps
module i2sc_partner (
   // Clock, reset and bench requests
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   input  wire logic raise_i,
   input  wire logic wake_ack_i,
   // Pending unmasked peripheral request
   output logic      irq_o
);
   // Like an interrupt controller, a request stays pending until acknowledged
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) irq_o <= 1'b0;
      else if (raise_i) irq_o <= 1'b1;
      else if (wake_ack_i) irq_o <= 1'b0;
   end
endmodule : i2sc_partner

/* File: verif/i2sc_ctrl_tb.sv */
`timescale 1ns/10ps
module i2sc_ctrl_tb;
   import i2sc_pkg::*;
   logic       clock_i, arst_n_i, wr_i, rd_i, nmi, rp, wdi, ins, en, pll, raise, irq;
   logic       ack, br, cont, rst, idle, halt, ret, cpuen, pllen, itm, wtm, wdt;
   logic [7:0] addr_i, wdata_i, rdata_o, p;
   logic [5:0] ser;
   logic [2:0] qp, sp;
   logic [8:0] xp, xm;
   int         fails = 0, num_checks = 0, cyc = 0, n;
   // Short reset interval keeps the reset wake quick
   i2sc_ctrl #(.RESET_STAB_CYCLES(16)) i_dut (.clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .nmi_pin_i(nmi), .external_irq_pins_i(xp), .reset_pin_i(rp),
      .watchdog_reset_i(1'b0), .low_voltage_detector_i(1'b0), .clock_monitor_i(1'b0),
      .watchdog_interrupt_i(wdi), .ext_irq_masked_i(xm), .periph_irq_unmasked_i(irq),
      .req_prio_i(qp), .in_service_i(ins), .svc_prio_i(sp), .int_enabled_i(en),
      .pll_on_i(pll), .cpu_clk_en_o(cpuen), .pll_enable_o(pllen), .flash_clk_en_o(),
      .dma_clk_en_o(), .gen_timer_clk_en_o(), .intc_clk_en_o(), .periph_clk_en_o(),
      .interval_timer_clk_en_o(itm), .watch_timer_clk_en_o(wtm), .watchdog_clk_en_o(wdt),
      .serial_clk_en_o(ser), .idle_o(idle), .cpu_halt_o(halt), .ram_retain_o(ret),
      .periph_hold_o(), .wake_ack_o(ack), .wake_branch_o(br), .wake_continue_o(cont),
      .system_reset_req_o(rst));
   i2sc_partner i_partner (.clock_i, .arst_n_i, .raise_i(raise), .wake_ack_i(ack), .irq_o(irq));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // Four wakes of about 4100 cycles and one reset wake of 16 fit well below this ceiling
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         test_done();
      end
   end
   task automatic tick(); @(posedge clock_i); #1; endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i); wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
      @(posedge clock_i); wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock_i); rd_i <= 1'b1; addr_i <= a;
      @(posedge clock_i); rd_i <= 1'b0;
      #1 chk(16'(rdata_o), 16'(e));
   endtask : rd
   // Entry write, then the software's no-op gap
   task automatic enter(input logic [7:0] c);
      wr(OFS_CTRL, c);
      repeat (5) tick();
   endtask : enter
   // Sample setup state, then count setup cycles up to the release pulse
   task automatic waitrel();
      while (idle !== 1'b0) tick();
      p[7:4] = {halt, ret, cpuen, pllen};
      n = 0;
      do begin tick(); n++; end while ((ack | br | cont | rst) !== 1'b1);
      p[3:0] = {ack, br, cont, rst};
   endtask : waitrel
   initial begin
      {arst_n_i, wr_i, rd_i, nmi, rp, wdi, ins, en, pll, raise, qp, sp} = '0;
      addr_i = '0; wdata_i = '0;
      xp = 9'h008; xm = 9'h1FF;
      repeat (4) @(posedge clock_i);
      arst_n_i <= 1'b1;
      rd(OFS_OSC_STABILIZE_SELECT_REG, 8'h04);
      rd(8'hFF, 8'h00);
      wr(OFS_MODE, 8'h01);
      enter(8'h02);
      chk(16'(idle), 16'h0000);
      wr(OFS_OSC_STABILIZE_SELECT_REG, 8'h00); wr(OFS_CLKCFG, 8'h05); wr(OFS_SERCFG, 8'h05); wr(OFS_MODE, 8'h02);
      pll <= 1'b1; en <= 1'b1; qp <= 3'h5; sp <= 3'h2;
      enter(8'h22); nmi <= 1'b1;
      chk(16'({idle, cpuen, pllen, itm, wtm, wdt, ser}), 16'h0985);
      repeat (10) tick();
      chk(16'(idle), 16'h0001);
      raise <= 1'b1; tick(); raise <= 1'b0;
      waitrel();
      chk(16'(n), 16'h1000);
      chk(16'(p), 16'h00DC);
      nmi <= 1'b0; pll <= 1'b0; ins <= 1'b1; raise <= 1'b1; tick(); raise <= 1'b0;
      enter(8'h02); waitrel();
      chk(16'(n <= 4096), 16'h0001);
      chk(16'({irq, p}), 16'h01C2);
      en <= 1'b0;
      enter(8'h12); repeat (10) tick();
      chk(16'(idle), 16'h0001);
      wdi <= 1'b1; waitrel(); wdi <= 1'b0;
      chk(16'(n), 16'h1000);
      chk(16'(p), 16'h00CC);
      enter(8'h12); rp <= 1'b1; waitrel(); rp <= 1'b0;
      chk(16'(n), 16'h0010);
      chk(16'(p), 16'h00C1);
      xm <= 9'h1F7; enter(8'h02); waitrel();
      chk(16'(n), 16'h0FFD);
      chk(16'(p), 16'h00C2);
      test_done();
   end
endmodule : i2sc_ctrl_tb
